// File: inc/sihc_pkg.sv
package sihc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned TICK_HZ          = 1000;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / TICK_HZ;
  localparam int unsigned FLASH_HALF_MS    = 500;
  localparam int unsigned FLICKER_HALF_MS  = 50;
  localparam int unsigned BACKLIGHT_MIN    = 10;
  localparam int unsigned BACKLIGHT_MS     = BACKLIGHT_MIN * 60 * 1000;
  localparam int unsigned SELFTEST_MS      = 2000;
  localparam int unsigned SPLASH_MS        = 1500;
  localparam int unsigned VERSION_MS       = 1500;

  // ****************************************************************
  // Temperature thresholds, signed tenths of a degree
  // ****************************************************************
  localparam logic signed [11:0] TEMP_RELEASE   = 12'sd150;
  localparam logic signed [11:0] HOUSING_OFF    = 12'sd180;
  localparam logic signed [11:0] HOUSING_ON     = 12'sd150;
  localparam logic signed [11:0] COVER_OFF      = 12'sd250;
  localparam logic signed [11:0] COVER_HYST     = 12'sd30;
  localparam logic signed [11:0] COVER_ON       = COVER_OFF - COVER_HYST;

  // ****************************************************************
  // Lamp colours and display pages
  // ****************************************************************
  typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_RED, LAMP_ORANGE} sihc_color_t;
  typedef enum logic [1:0] {PORT_OFF, PORT_GREEN, PORT_YELLOW} sihc_port_t;
  typedef enum logic [2:0] {
    PG_SPLASH, PG_VERSION_START, PG_POSITION, PG_QUALITY, PG_DEVICE_STATUS,
    PG_IO_STATUS, PG_DEVICE_NAME, PG_VERSION
  } sihc_page_t;
  typedef enum logic [1:0] {ST_OK, ST_WARNING, ST_ERROR} sihc_status_t;

  localparam int unsigned NAME_MAX_CHARS = 240;
  localparam logic [7:0]  DEC_POINT      = 8'h2e;
  localparam logic [6:0]  QUALITY_MAX    = 7'h64;
  localparam logic [7:0]  SW_VERSION     = 8'h13; // Arbitrary value
  localparam logic [3:0]  HW_VERSION     = 4'h1;  // Arbitrary value

endpackage

// File: rtl/sihc_top.sv
`timescale 1ns/1ps

// Behaviour
// - Heated unit: only heaters powered until inside exceeds release temperature.
// - After supply: self test, then read operation; power lamp shows readiness.
// - Housing heater off at upper threshold, on below lower; reading continues.
// - Cover heater off at its upper threshold, on three degrees lower.
// - Power lamp flashes green initialising, steady green when measuring.
// - Power lamp flashes red while a warning is set.
// - Power lamp steady red on device error; error is logged.
// - Locate active: power and bus lamps flash orange.
// - Service mode: power lamp steady orange, no host data, USB configuration.
// - Bus lamp flashes green while waiting for host communication.
// - Bus lamp steady green while data exchange is active.
// - Bus lamp flashes red on failed configuration; off without supply.
// - Port lamps green on link, flicker yellow during traffic.
// - Any button press lights backlight; it goes off after timeout.
// - Two-line display: function name on top, function data below.
// - Position signed in millimetres with point; quality in percent.
// - Status OK, warning or error; switch lines shown as direction and state.
// - Device name page scrolls bounded text; version page shows versions.
// - Quality page selected while measurement stopped switches laser on.
// - Enter toggles page-shift mode, down steps pages.
// - Settings and name are loaded from hood memory into the unit.
// - Two switching lines, each configurable as input or output.
// - Shift mode flashes display; down advances pages; enter fixes page.
// - Start-up screen, then version, then position page.
module sihc_top
  import sihc_pkg::*;
#(
  parameter int unsigned BACKLIGHT_TICKS = BACKLIGHT_MS,
  parameter int unsigned SELFTEST_TICKS  = SELFTEST_MS
)
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               heated_model,
  input  wire logic signed [11:0] inside_temp,
  input  wire logic               selftest_pass,
  input  wire logic               warning_set,
  input  wire logic               device_error,
  input  wire logic [7:0]         error_code,
  input  wire logic               locate_active,
  input  wire logic               service_mode,
  input  wire logic               bus_waiting,
  input  wire logic               bus_exchange,
  input  wire logic               bus_config_fail,
  input  wire logic [1:0]         port_link,
  input  wire logic [1:0]         port_activity,
  input  wire logic               btn_enter_n,
  input  wire logic               btn_down_n,
  input  wire logic               measure_stopped,
  input  wire logic signed [23:0] position_tenth_mm,
  input  wire logic [6:0]         read_quality,
  input  wire logic [1:0]         switch_dir_cfg,
  input  wire logic [1:0]         switch_out_val,
  input  wire logic [1:0]         switch_pin_in,
  input  wire logic               hood_mem_valid,
  input  wire logic [7:0]         hood_name_len,
  output logic                    housing_heater_en,
  output logic                    cover_heater_en,
  output logic                    electronics_supply_en,
  output logic                    read_active,
  output sihc_color_t             power_status_lamp,
  output sihc_color_t             bus_status_lamp,
  output sihc_port_t              port0_link_activity_lamp,
  output sihc_port_t              port1_link_activity_lamp,
  output logic                    backlight_on,
  output sihc_page_t              display_page,
  output logic                    display_visible,
  output logic                    laser_force_on,
  output logic                    host_data_en,
  output logic                    usb_config_en,
  output logic                    log_write,
  output logic [7:0]              log_code,
  output logic                    position_negative,
  output logic [23:0]             position_magnitude,
  output logic [7:0]              decimal_char,
  output logic [6:0]              quality_percent,
  output sihc_status_t            device_status,
  output logic [1:0]              switch_line_oe,
  output logic [1:0]              switch_line_out,
  output logic [1:0]              switch_line_in,
  output logic                    params_loaded,
  output logic [7:0]              ticker_len,
  output logic [7:0]              version_sw,
  output logic [3:0]              version_hw
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int unsigned NSYNC = 6;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  wire  [NSYNC-1:0] sync_in = {btn_enter_n, btn_down_n, switch_pin_in, port_activity};

  // Pins from the outside world; only the second stage is read by logic
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  wire       enter_n_s = sync2_r[5];
  wire       down_n_s  = sync2_r[4];
  wire [1:0] pin_in_s  = sync2_r[3:2];
  wire [1:0] act_s     = sync2_r[1:0];

  // ****************************************************************
  // Millisecond tick and blink phases
  // ****************************************************************
  logic [15:0] tick_cnt_r;
  logic [9:0]  flash_cnt_r;
  logic [6:0]  flick_cnt_r;
  logic        flash_ph_r;
  logic        flick_ph_r;
  wire         tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  // One shared flash phase keeps the power and bus lamps in step; port lamps use the flicker phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_r  <= 16'h0000;
      flash_cnt_r <= 10'h000;
      flick_cnt_r <= 7'h00;
      flash_ph_r  <= 1'b0;
      flick_ph_r  <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (tick)
      begin
        flash_cnt_r <= (flash_cnt_r == 10'(FLASH_HALF_MS - 1)) ? 10'h000 : flash_cnt_r + 10'h001;
        flick_cnt_r <= (flick_cnt_r == 7'(FLICKER_HALF_MS - 1)) ? 7'h00 : flick_cnt_r + 7'h01;
        if (flash_cnt_r == 10'(FLASH_HALF_MS - 1))
          flash_ph_r <= ~flash_ph_r;
        if (flick_cnt_r == 7'(FLICKER_HALF_MS - 1))
          flick_ph_r <= ~flick_ph_r;
      end
    end
  end

  // ****************************************************************
  // Heater sequencing
  // ****************************************************************
  wire above_release = inside_temp > TEMP_RELEASE;
  wire housing_off   = inside_temp >= HOUSING_OFF;
  wire housing_on    = inside_temp < HOUSING_ON;
  wire cover_off     = inside_temp >= COVER_OFF;
  wire cover_on      = inside_temp < COVER_ON;

  // Hysteresis keeps the heaters from chattering around a single threshold
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      housing_heater_en     <= 1'b0;
      cover_heater_en       <= 1'b0;
      electronics_supply_en <= 1'b0;
    end
    else if (!heated_model)
    begin
      housing_heater_en     <= 1'b0;
      cover_heater_en       <= 1'b0;
      electronics_supply_en <= 1'b1;
    end
    else
    begin
      if (above_release)
        electronics_supply_en <= 1'b1;
      if (housing_off)
        housing_heater_en <= 1'b0;
      else if (housing_on)
        housing_heater_en <= 1'b1;
      if (cover_off)
        cover_heater_en <= 1'b0;
      else if (cover_on)
        cover_heater_en <= 1'b1;
    end
  end

  // ****************************************************************
  // Self test and parameter load
  // ****************************************************************
  logic [31:0] st_cnt_r;
  wire         st_done = st_cnt_r >= SELFTEST_TICKS;

  // Supply loss is not modelled: once released the supply latch holds
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_cnt_r      <= 32'h0;
      read_active   <= 1'b0;
      params_loaded <= 1'b0;
      ticker_len    <= 8'h00;
    end
    else if (electronics_supply_en)
    begin
      if (tick && !st_done)
        st_cnt_r <= st_cnt_r + 32'h1;
      if (hood_mem_valid && !params_loaded)
      begin
        params_loaded <= 1'b1;
        ticker_len    <= (hood_name_len > 8'(NAME_MAX_CHARS)) ? 8'(NAME_MAX_CHARS)
                                                               : hood_name_len;
      end
      if (st_done && selftest_pass)
        read_active <= 1'b1;
    end
  end

  // ****************************************************************
  // Status lamps
  // ****************************************************************
  sihc_color_t pwr_nxt;
  sihc_color_t bus_nxt;

  // Priority: service, locate, error, warning, initialising, running
  always_comb
  begin
    if (!electronics_supply_en)
      pwr_nxt = LAMP_OFF;
    else if (service_mode)
      pwr_nxt = LAMP_ORANGE;
    else if (locate_active)
      pwr_nxt = flash_ph_r ? LAMP_ORANGE : LAMP_OFF;
    else if (device_error)
      pwr_nxt = LAMP_RED;
    else if (warning_set)
      pwr_nxt = flash_ph_r ? LAMP_RED : LAMP_OFF;
    else if (!read_active)
      pwr_nxt = flash_ph_r ? LAMP_GREEN : LAMP_OFF;
    else
      pwr_nxt = LAMP_GREEN;
  end

  // Bus lamp; a failed configuration overrides a stale waiting state
  always_comb
  begin
    if (!electronics_supply_en)
      bus_nxt = LAMP_OFF;
    else if (locate_active)
      bus_nxt = flash_ph_r ? LAMP_ORANGE : LAMP_OFF;
    else if (bus_config_fail)
      bus_nxt = flash_ph_r ? LAMP_RED : LAMP_OFF;
    else if (bus_exchange)
      bus_nxt = LAMP_GREEN;
    else if (bus_waiting)
      bus_nxt = flash_ph_r ? LAMP_GREEN : LAMP_OFF;
    else
      bus_nxt = LAMP_OFF;
  end

  sihc_port_t port_nxt [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      // Traffic flicker wins over the steady link colour
      assign port_nxt[gi] = !port_link[gi] ? PORT_OFF :
                            (act_s[gi] && flick_ph_r) ? PORT_YELLOW : PORT_GREEN;
    end
  endgenerate

  logic err_seen_r;

  // Lamp registers and the one-shot event log write per error episode
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_status_lamp        <= LAMP_OFF;
      bus_status_lamp          <= LAMP_OFF;
      port0_link_activity_lamp <= PORT_OFF;
      port1_link_activity_lamp <= PORT_OFF;
      err_seen_r               <= 1'b0;
      log_write                <= 1'b0;
      log_code                 <= 8'h00;
      host_data_en             <= 1'b0;
      usb_config_en            <= 1'b0;
    end
    else
    begin
      power_status_lamp        <= pwr_nxt;
      bus_status_lamp          <= bus_nxt;
      port0_link_activity_lamp <= port_nxt[0];
      port1_link_activity_lamp <= port_nxt[1];
      err_seen_r               <= device_error;
      log_write                <= device_error && !err_seen_r;
      if (device_error && !err_seen_r)
        log_code <= error_code;
      host_data_en             <= read_active && !service_mode;
      usb_config_en            <= service_mode;
    end
  end

  // ****************************************************************
  // Buttons, backlight and page menu
  // ****************************************************************
  logic        enter_d_r;
  logic        down_d_r;
  logic        shift_r;
  logic [31:0] bl_cnt_r;
  logic [31:0] boot_cnt_r;
  wire         enter_press = !enter_n_s && enter_d_r;
  wire         down_press  = !down_n_s && down_d_r;
  wire         any_press   = enter_press || down_press;
  wire         booting     = (display_page == PG_SPLASH) || (display_page == PG_VERSION_START);
  wire         boot_step   = tick && (boot_cnt_r == 32'(SPLASH_MS - 1));
  sihc_page_t  page_step;

  // Wraps from the version page back to position
  assign page_step = (display_page == PG_VERSION) ? PG_POSITION
                                                  : sihc_page_t'(display_page + 3'h1);

  // Boot screens ignore buttons for paging and shift mode so the start-up order is always seen; presses still light the backlight
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enter_d_r       <= 1'b1;
      down_d_r        <= 1'b1;
      shift_r         <= 1'b0;
      bl_cnt_r        <= 32'h0;
      backlight_on    <= 1'b0;
      boot_cnt_r      <= 32'h0;
      display_page    <= PG_SPLASH;
      display_visible <= 1'b1;
      laser_force_on  <= 1'b0;
    end
    else
    begin
      enter_d_r <= enter_n_s;
      down_d_r  <= down_n_s;
      if (any_press)
      begin
        backlight_on <= 1'b1;
        bl_cnt_r     <= 32'h0;
      end
      else if (tick && backlight_on)
      begin
        bl_cnt_r <= bl_cnt_r + 32'h1;
        if (bl_cnt_r == BACKLIGHT_TICKS - 1)
          backlight_on <= 1'b0;
      end
      if (booting)
      begin
        if (tick)
          boot_cnt_r <= boot_step ? 32'h0 : boot_cnt_r + 32'h1;
        if (boot_step && read_active)
          display_page <= (display_page == PG_SPLASH) ? PG_VERSION_START
                                                      : PG_POSITION;
      end
      else
      begin
        if (enter_press)
          shift_r <= ~shift_r;
        else if (down_press && shift_r)
          display_page <= page_step;
      end
      display_visible <= !shift_r || flash_ph_r;
      laser_force_on  <= measure_stopped && (display_page == PG_QUALITY);
    end
  end

  // ****************************************************************
  // Page data: name on top comes from the page code, data below
  // ****************************************************************
  wire [23:0] pos_abs = position_tenth_mm[23] ? 24'(-position_tenth_mm)
                                              : position_tenth_mm;

  // Data lines feed the character generator of the two-line panel
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      position_negative  <= 1'b0;
      position_magnitude <= 24'h0;
      decimal_char       <= DEC_POINT;
      quality_percent    <= 7'h00;
      device_status      <= ST_OK;
      switch_line_oe     <= 2'b00;
      switch_line_out    <= 2'b00;
      switch_line_in     <= 2'b00;
      version_sw         <= SW_VERSION;
      version_hw         <= HW_VERSION;
    end
    else
    begin
      position_negative  <= position_tenth_mm[23];
      position_magnitude <= pos_abs;
      decimal_char       <= DEC_POINT;
      quality_percent    <= (read_quality > QUALITY_MAX) ? QUALITY_MAX : read_quality;
      device_status      <= device_error ? ST_ERROR :
                            warning_set ? ST_WARNING : ST_OK;
      switch_line_oe     <= switch_dir_cfg;
      switch_line_out    <= switch_out_val & switch_dir_cfg;
      switch_line_in     <= (pin_in_s & ~switch_dir_cfg)
                            | (switch_out_val & switch_dir_cfg);
      version_sw         <= SW_VERSION;
      version_hw         <= HW_VERSION;
    end
  end

endmodule // sihc_top

// File: tb/sihc_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// Port-level checker for the indicator and heater block
// ****************************************************************
module sihc_chk
  import sihc_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               heated_model,
  input wire logic signed [11:0] inside_temp,
  input wire logic               service_mode,
  input wire logic               locate_active,
  input wire logic               device_error,
  input wire logic [7:0]         error_code,
  input wire logic               electronics_supply_en,
  input wire logic               housing_heater_en,
  input wire logic               cover_heater_en,
  input wire sihc_color_t        power_status_lamp,
  input wire sihc_color_t        bus_status_lamp,
  input wire logic               usb_config_en,
  input wire logic               host_data_en,
  input wire logic               log_write,
  input wire logic [7:0]         log_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Supply is released only once the inside is warm enough, then latched
  property p_release;
    heated_model && inside_temp > TEMP_RELEASE |=> electronics_supply_en;
  endproperty
  a_release: assert property (p_release) else $error("supply not released");
  property p_hold_off;
    heated_model && !electronics_supply_en && inside_temp <= TEMP_RELEASE |=> !electronics_supply_en;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("supply released cold");
  // Housing heater thresholds
  property p_housing;
    heated_model && inside_temp >= HOUSING_OFF |=> !housing_heater_en;
  endproperty
  a_housing: assert property (p_housing) else $error("housing heater not off");
  property p_housing_on;
    heated_model && inside_temp < HOUSING_ON |=> housing_heater_en;
  endproperty
  a_housing_on: assert property (p_housing_on) else $error("housing heater not on");
  // Cover heater holds its state inside the hysteresis band
  property p_cover_band;
    heated_model && inside_temp >= COVER_ON && inside_temp < COVER_OFF
      |=> cover_heater_en == $past(cover_heater_en);
  endproperty
  a_cover_band: assert property (p_cover_band) else $error("cover band broken");
  property p_cover_off;
    inside_temp >= COVER_OFF |=> !cover_heater_en;
  endproperty
  a_cover_off: assert property (p_cover_off) else $error("cover heater not off");
  // Service mode outranks everything on the power lamp
  property p_service;
    electronics_supply_en && service_mode
      |=> power_status_lamp == LAMP_ORANGE && usb_config_en && !host_data_en;
  endproperty
  a_service: assert property (p_service) else $error("service indication wrong");
  property p_error;
    electronics_supply_en && !service_mode && !locate_active && device_error
      |=> power_status_lamp == LAMP_RED;
  endproperty
  a_error: assert property (p_error) else $error("error lamp wrong");
  property p_dark;
    !electronics_supply_en |=> power_status_lamp == LAMP_OFF && bus_status_lamp == LAMP_OFF;
  endproperty
  a_dark: assert property (p_dark) else $error("lamp lit unsupplied");
  // One log entry per error onset, carrying the code seen at the onset
  property p_log;
    $rose(device_error) |=> log_write && log_code == $past(error_code) ##1 !log_write;
  endproperty
  a_log: assert property (p_log) else $error("log pulse wrong");

  c_release: cover property (heated_model && inside_temp > TEMP_RELEASE);
  c_service: cover property (electronics_supply_en && service_mode);
  c_log: cover property ($rose(device_error));
endmodule // sihc_chk

bind sihc_top sihc_chk u_chk (.sys_clk, .rst_n, .heated_model, .inside_temp, .service_mode,
  .locate_active, .device_error, .error_code, .electronics_supply_en, .housing_heater_en,
  .cover_heater_en, .power_status_lamp, .bus_status_lamp, .usb_config_en, .host_data_en,
  .log_write, .log_code);

// File: tb/sihc_operator.sv
`timescale 1ns/1ps

// ****************************************************************
// Operator model: presses one button at a time
// ****************************************************************
module sihc_operator
(
  input  wire logic sys_clk,
  input  wire logic press_enter,
  input  wire logic press_down,
  output logic      btn_enter_n,
  output logic      btn_down_n
);
  logic [3:0] hold_r = 4'h0;
  logic       sel_r  = 1'b0;

  // Pin low 6 cycles, then high 7 cycles before another press is taken
  always_ff @(posedge sys_clk)
  begin
    if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
    else if (press_enter || press_down)
    begin
      hold_r <= 4'hc;
      sel_r  <= press_down;
    end
  end
  assign btn_enter_n = !(hold_r > 4'h6 && !sel_r);
  assign btn_down_n  = !(hold_r > 4'h6 && sel_r);
endmodule // sihc_operator

// File: tb/status_indicator_heater_ctrl_tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench
// ****************************************************************
module status_indicator_heater_ctrl_tb
  import sihc_pkg::*;
;
  logic sys_clk, rst_n, heated_model, selftest_pass, warning_set, device_error;
  logic locate_active, service_mode, bus_waiting, bus_exchange, bus_config_fail;
  logic measure_stopped, hood_mem_valid, press_enter, press_down, btn_enter_n, btn_down_n;
  logic signed [11:0] inside_temp;
  logic signed [23:0] position_tenth_mm;
  logic [7:0]  error_code, hood_name_len, ticker_len, log_code, decimal_char, version_sw;
  logic [1:0]  port_link, port_activity, switch_dir_cfg, switch_out_val, switch_pin_in;
  logic [1:0]  switch_line_oe, switch_line_out, switch_line_in;
  logic [6:0]  read_quality, quality_percent;
  logic [23:0] position_magnitude;
  logic [3:0]  version_hw;
  logic housing_heater_en, cover_heater_en, electronics_supply_en, read_active, backlight_on;
  logic display_visible, laser_force_on, host_data_en, usb_config_en, log_write;
  logic position_negative, params_loaded;
  sihc_color_t  power_status_lamp, bus_status_lamp;
  sihc_port_t   port0_link_activity_lamp, port1_link_activity_lamp;
  sihc_page_t   display_page;
  sihc_status_t device_status;
  int fails, checked, cyc;

  sihc_top #(.BACKLIGHT_TICKS(20), .SELFTEST_TICKS(3)) u_dut (.*);
  sihc_operator u_op (.sys_clk, .press_enter, .press_down, .btn_enter_n, .btn_down_n);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_heat();
    logic [11:0] tt [12] = '{12'hf38, 12'h096, 12'h097, 12'h0b3, 12'h0b4, 12'h096,
                             12'h095, 12'h0f9, 12'h0fa, 12'h0dc, 12'h0db, 12'h064};
    logic [2:0]  ex [12] = '{3'h3, 3'h3, 3'h7, 3'h7, 3'h5, 3'h5, 3'h7, 3'h5, 3'h4, 3'h4,
                             3'h5, 3'h7};
    for (int i = 0; i < 12; i++)
    begin
      @(posedge sys_clk);
      inside_temp <= tt[i];
      settle(3);
      chk({electronics_supply_en, housing_heater_en, cover_heater_en}, ex[i]);
    end
    $display("heater sequencing done");
  endtask
  task automatic t_power();
    logic [3:0]   in [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
    sihc_color_t  ex [5] = '{LAMP_ORANGE, LAMP_OFF, LAMP_RED, LAMP_OFF, LAMP_OFF};
    sihc_status_t st [5] = '{ST_ERROR, ST_ERROR, ST_ERROR, ST_WARNING, ST_OK};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      {service_mode, locate_active, device_error, warning_set} <= in[i];
      settle(3);
      chk(power_status_lamp, ex[i]);
      chk(device_status, st[i]);
    end
    $display("power lamp done");
  endtask
  task automatic t_bus();
    logic [3:0]  in [4] = '{4'h2, 4'h6, 4'h1, 4'ha};
    sihc_color_t ex [4] = '{LAMP_GREEN, LAMP_OFF, LAMP_OFF, LAMP_OFF};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {locate_active, bus_config_fail, bus_exchange, bus_waiting} <= in[i];
      settle(3);
      chk(bus_status_lamp, ex[i]);
    end
    $display("bus lamp done");
  endtask
  task automatic t_ports();
    for (int i = 1; i < 3; i++)
    begin
      @(posedge sys_clk);
      port_link <= 2'(i);
      settle(3);
      chk({port1_link_activity_lamp, port0_link_activity_lamp}, (i == 1) ? 4'h1 : 4'h4);
    end
    $display("port lamps done");
  endtask
  task automatic t_log();
    chk(log_write, 1'b0);
    @(posedge sys_clk);
    error_code <= 8'h5a;
    device_error <= 1'b1;
    settle(1);
    chk({log_write, log_code}, 9'h15a);
    settle(1);
    chk(log_write, 1'b0);
    @(posedge sys_clk);
    device_error <= 1'b0;
    $display("error log done");
  endtask
  task automatic t_data();
    @(posedge sys_clk);
    position_tenth_mm <= 24'hffcfc7;
    read_quality <= 7'h7f;
    switch_dir_cfg <= 2'h1;
    switch_pin_in <= 2'h2;
    settle(5);
    chk({position_negative, position_magnitude}, 25'h1003039);
    chk({decimal_char, quality_percent}, {DEC_POINT, QUALITY_MAX});
    chk({switch_line_oe, switch_line_in}, 4'h6);
    chk({params_loaded, ticker_len}, 9'h1f0);
    chk({version_sw, version_hw}, {SW_VERSION, HW_VERSION});
    $display("display data done");
  endtask
  task automatic t_boot_buttons();
    @(posedge sys_clk);
    press_enter <= 1'b1;
    @(posedge sys_clk);
    press_enter <= 1'b0;
    settle(14);
    @(posedge sys_clk);
    press_down <= 1'b1;
    @(posedge sys_clk);
    press_down <= 1'b0;
    settle(14);
    chk({backlight_on, display_page, display_visible}, {1'b1, PG_SPLASH, 1'b1});
    $display("boot buttons done");
  endtask

  // Timeout guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    {rst_n, selftest_pass, warning_set, device_error, locate_active, service_mode} = '0;
    {bus_waiting, bus_exchange, bus_config_fail, measure_stopped, press_enter, press_down} = '0;
    {port_link, port_activity, switch_out_val, switch_dir_cfg, switch_pin_in} = '0;
    {fails, checked, cyc} = '0;
    heated_model = 1'b1;
    hood_mem_valid = 1'b1;
    hood_name_len = 8'hff;
    inside_temp = 12'hf38;
    error_code = 8'h00;
    position_tenth_mm = 24'h000000;
    read_quality = 7'h00;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_heat();
    t_power();
    t_bus();
    t_ports();
    t_log();
    t_data();
    t_boot_buttons();
    results();
  end
endmodule // status_indicator_heater_ctrl_tb
